//--- cmc_cfg.svh
// Register offsets, field positions, reset values and fixed codes of
// the compare output mode controller.
// Assumes a Wishbone byte address of four bits, one aligned word each.
`ifndef CMC_CFG_SVH
`define CMC_CFG_SVH

`define CMC_ADR_W 4
`define CMC_ADR_CTRL 4'h0
`define CMC_ADR_CMPA 4'h4
`define CMC_ADR_CMPB 4'h8
`define CMC_ADR_STAT 4'hC

`define CMC_CTRL_PWMB 0
`define CMC_CTRL_PWMA 1
`define CMC_CTRL_BOM 4
`define CMC_CTRL_AOM 6
`define CMC_CTRL_WGM 8
`define CMC_CTRL_RST 10'h000
`define CMC_CMP_RST 10'h000

`define CMC_STAT_WAVE_A 0
`define CMC_STAT_WAVE_B 1
`define CMC_STAT_ATT_A 2
`define CMC_STAT_NATT_A 3
`define CMC_STAT_ATT_B 4
`define CMC_STAT_NATT_B 5
`define CMC_STAT_MATCH_A 6
`define CMC_STAT_MATCH_B 7

`define CMC_OM_OFF 2'h0
`define CMC_OM_TOGGLE 2'h1
`define CMC_OM_CLEAR 2'h2
`define CMC_OM_SET 2'h3
`define CMC_BOTTOM 10'h000

`endif

//--- cmc_chan_if.sv
// Per-channel link between the controller and its waveform unit.
// Assumes all signals live on the controller clock.
`timescale 1ns/100ps

interface cmc_chan_if;
    import cmc_pkg::*;
    cmc_mode_t mode;
    logic [1:0] outmode;
    logic match;
    logic bottom;
    logic down;
    logic waveform;

    modport ctl(output mode, output outmode, output match, output bottom,
                output down, input waveform);
    modport unit(input mode, input outmode, input match, input bottom,
                 input down, output waveform);
endinterface : cmc_chan_if

//--- cmc_pkg.sv
// Types and shared helpers of the compare output mode controller.
// Assumes cmc_cfg.svh for field codes.
`include "cmc_cfg.svh"

package cmc_pkg;

    // Gray along normal, fast, dual-slope, six-output single, dual
    typedef enum logic [2:0] {
        CMC_M_NORMAL = 3'h0,
        CMC_M_FAST = 3'h1,
        CMC_M_PFC = 3'h3,
        CMC_M_SS6 = 3'h2,
        CMC_M_DS6 = 3'h6
    } cmc_mode_t;

    // Channel B passes only bit 0 of the selection, bit 1 tied low
    function automatic cmc_mode_t cmc_decode(input logic pwm,
                                             input logic [1:0] wgm);
        cmc_mode_t m;
        m = CMC_M_NORMAL;
        if (pwm) begin
            case (wgm)
                2'h0: m = CMC_M_FAST;
                2'h1: m = CMC_M_PFC;
                2'h2: m = CMC_M_SS6;
                2'h3: m = CMC_M_DS6;
                default: m = CMC_M_NORMAL;
            endcase
        end
        return m;
    endfunction : cmc_decode

    function automatic logic cmc_six(input cmc_mode_t m);
        return (m == CMC_M_SS6) || (m == CMC_M_DS6);
    endfunction : cmc_six

    // Complementary pin: PWM with code 01, or any nonzero code in six-out
    function automatic logic cmc_comp_attach(input cmc_mode_t m,
                                             input logic [1:0] om);
        return ((m != CMC_M_NORMAL) && (om == `CMC_OM_TOGGLE)) ||
               (cmc_six(m) && (om != `CMC_OM_OFF));
    endfunction : cmc_comp_attach

    // Byte-lane merge of a 10-bit field
    function automatic logic [9:0] cmc_merge10(input logic [9:0] old,
                                               input logic [31:0] dat,
                                               input logic [3:0] sel);
        logic [9:0] r;
        r = old;
        if (sel[0]) begin
            r[7:0] = dat[7:0];
        end
        if (sel[1]) begin
            r[9:8] = dat[9:8];
        end
        return r;
    endfunction : cmc_merge10

endpackage : cmc_pkg

//--- cmc_top.sv
// Compare output mode controller for channels A and B of a 10-bit
// timer, with a classic Wishbone register slave.
// Assumes the counter, its direction and the general-purpose port values
// come from logic on clock_i, so none of them is synchronised here.
`timescale 1ns/100ps
`include "cmc_cfg.svh"

module cmc_top
    import cmc_pkg::*;
(
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic [9:0] fast_timer_count_i,
    input wire logic count_down_i,
    input wire logic port_a_i,
    input wire logic port_a_n_i,
    input wire logic port_b_i,
    input wire logic port_b_n_i,
    output logic chan_a_compare_pin_o,
    output logic chan_a_compare_pin_n_o,
    output logic chan_b_compare_pin_o,
    output logic chan_b_compare_pin_n_o,
    output logic chan_a_attach_o,
    output logic chan_a_n_attach_o,
    output logic chan_b_attach_o,
    output logic chan_b_n_attach_o,
    output logic chan_a_waveform_o,
    output logic chan_b_waveform_o
);

    logic [1:0] chan_a_outmode;
    logic [1:0] chan_b_outmode;
    logic chan_a_pwm_enable;
    logic chan_b_pwm_enable;
    logic waveform_gen_sel_bit0;
    logic waveform_gen_sel_bit1;
    logic [9:0] chan_a_compare_value;
    logic [9:0] chan_b_compare_value;
    logic match_a_seen;
    logic match_b_seen;

    logic bus_req;
    logic bus_wr;
    logic [9:0] ctrl_word;
    logic [9:0] next_ctrl;
    logic [7:0] status_word;

    cmc_mode_t mode_a;
    cmc_mode_t mode_b;
    logic six_out;
    logic match_a;
    logic match_b;
    logic at_bottom;
    logic wave_a;
    logic wave_b;
    logic att_a;
    logic natt_a;
    logic att_b;
    logic natt_b;

    cmc_chan_if chan_a_if ();
    cmc_chan_if chan_b_if ();

    // Mode decode
    assign mode_a = cmc_decode(chan_a_pwm_enable,
        {waveform_gen_sel_bit1, waveform_gen_sel_bit0});
    assign mode_b = cmc_decode(chan_b_pwm_enable,
        {1'b0, waveform_gen_sel_bit0});
    assign six_out = cmc_six(mode_a);

    // Compare against each channel's own value, same cycle
    assign match_a = (fast_timer_count_i == chan_a_compare_value);
    assign match_b = (fast_timer_count_i == chan_b_compare_value);
    assign at_bottom = (fast_timer_count_i == `CMC_BOTTOM);

    assign chan_a_if.mode = mode_a;
    assign chan_a_if.outmode = chan_a_outmode;
    assign chan_a_if.match = match_a;
    assign chan_a_if.bottom = at_bottom;
    assign chan_a_if.down = count_down_i;
    assign chan_b_if.mode = mode_b;
    assign chan_b_if.outmode = chan_b_outmode;
    assign chan_b_if.match = match_b;
    assign chan_b_if.bottom = at_bottom;
    assign chan_b_if.down = count_down_i;
    assign wave_a = chan_a_if.waveform;
    assign wave_b = chan_b_if.waveform;

    cmc_wave_unit u_wave_a (
        .clock_i(clock_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .ch(chan_a_if.unit)
    );

    cmc_wave_unit u_wave_b (
        .clock_i(clock_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .ch(chan_b_if.unit)
    );

    // Pin ownership; six-output hands the B pair to channel A
    assign att_a = (chan_a_outmode != `CMC_OM_OFF);
    assign natt_a = cmc_comp_attach(mode_a, chan_a_outmode);
    assign att_b = six_out ? att_a :
        (chan_b_outmode != `CMC_OM_OFF);
    assign natt_b = six_out ? natt_a :
        cmc_comp_attach(mode_b, chan_b_outmode);

    // Pins are registered so pin and attach flags change together.
    // Direction bits live in port logic; drivers follow them there.
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            chan_a_compare_pin_o <= 1'b0;
            chan_a_compare_pin_n_o <= 1'b0;
            chan_a_attach_o <= 1'b0;
            chan_a_n_attach_o <= 1'b0;
        end else if (ce_i) begin
            chan_a_compare_pin_o <= att_a ? wave_a : port_a_i;
            chan_a_compare_pin_n_o <= natt_a ? ~wave_a : port_a_n_i;
            chan_a_attach_o <= att_a;
            chan_a_n_attach_o <= natt_a;
        end
    end

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            chan_b_compare_pin_o <= 1'b0;
            chan_b_compare_pin_n_o <= 1'b0;
            chan_b_attach_o <= 1'b0;
            chan_b_n_attach_o <= 1'b0;
        end else if (ce_i) begin
            if (six_out) begin
                chan_b_compare_pin_o <= att_b ? wave_a : port_b_i;
                chan_b_compare_pin_n_o <= natt_b ? ~wave_a : port_b_n_i;
            end else begin
                chan_b_compare_pin_o <= att_b ? wave_b : port_b_i;
                chan_b_compare_pin_n_o <= natt_b ? ~wave_b : port_b_n_i;
            end
            chan_b_attach_o <= att_b;
            chan_b_n_attach_o <= natt_b;
        end
    end

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            chan_a_waveform_o <= 1'b0;
            chan_b_waveform_o <= 1'b0;
        end else if (ce_i) begin
            chan_a_waveform_o <= wave_a;
            chan_b_waveform_o <= wave_b;
        end
    end

    // Sticky-free match snapshot for software, last cycle only
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            match_a_seen <= 1'b0;
            match_b_seen <= 1'b0;
        end else if (ce_i) begin
            match_a_seen <= match_a;
            match_b_seen <= match_b;
        end
    end

    // Wishbone: ack one cycle after the request, write lands on the
    // edge that samples ack, so a request held past ack writes again every second cycle.
    assign bus_req = wb_cyc_i & wb_stb_i;
    assign bus_wr = bus_req & wb_we_i & wb_ack_o & ce_i;

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
        end else if (ce_i) begin
            wb_ack_o <= bus_req & ~wb_ack_o;
        end
    end

    assign ctrl_word = {waveform_gen_sel_bit1, waveform_gen_sel_bit0,
                        chan_a_outmode, chan_b_outmode, 2'h0,
                        chan_a_pwm_enable, chan_b_pwm_enable};
    assign next_ctrl = cmc_merge10(ctrl_word, wb_dat_i, wb_sel_i);

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            {waveform_gen_sel_bit1, waveform_gen_sel_bit0} <=
                2'(`CMC_CTRL_RST >> `CMC_CTRL_WGM);
            chan_a_outmode <= 2'h0;
            chan_b_outmode <= 2'h0;
            chan_a_pwm_enable <= 1'b0;
            chan_b_pwm_enable <= 1'b0;
        end else if (bus_wr && wb_adr_i == `CMC_ADR_CTRL) begin
            {waveform_gen_sel_bit1, waveform_gen_sel_bit0} <=
                next_ctrl[`CMC_CTRL_WGM +: 2];
            chan_a_outmode <= next_ctrl[`CMC_CTRL_AOM +: 2];
            chan_b_outmode <= next_ctrl[`CMC_CTRL_BOM +: 2];
            chan_a_pwm_enable <= next_ctrl[`CMC_CTRL_PWMA];
            chan_b_pwm_enable <= next_ctrl[`CMC_CTRL_PWMB];
        end
    end

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            chan_a_compare_value <= `CMC_CMP_RST;
            chan_b_compare_value <= `CMC_CMP_RST;
        end else if (bus_wr) begin
            if (wb_adr_i == `CMC_ADR_CMPA) begin
                chan_a_compare_value <=
                    cmc_merge10(chan_a_compare_value, wb_dat_i, wb_sel_i);
            end
            if (wb_adr_i == `CMC_ADR_CMPB) begin
                chan_b_compare_value <=
                    cmc_merge10(chan_b_compare_value, wb_dat_i, wb_sel_i);
            end
        end
    end

    always_comb begin
        status_word = 8'h00;
        status_word[`CMC_STAT_WAVE_A] = wave_a;
        status_word[`CMC_STAT_WAVE_B] = wave_b;
        status_word[`CMC_STAT_ATT_A] = att_a;
        status_word[`CMC_STAT_NATT_A] = natt_a;
        status_word[`CMC_STAT_ATT_B] = att_b;
        status_word[`CMC_STAT_NATT_B] = natt_b;
        status_word[`CMC_STAT_MATCH_A] = match_a_seen;
        status_word[`CMC_STAT_MATCH_B] = match_b_seen;
    end

    // Unmapped offsets read zero and ignore writes
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            wb_dat_o <= 32'h0000_0000;
        end else if (ce_i) begin
            case (wb_adr_i)
                `CMC_ADR_CTRL: wb_dat_o <= {22'h0, ctrl_word};
                `CMC_ADR_CMPA: wb_dat_o <= {22'h0, chan_a_compare_value};
                `CMC_ADR_CMPB: wb_dat_o <= {22'h0, chan_b_compare_value};
                `CMC_ADR_STAT: wb_dat_o <= {24'h000000, status_word};
                default: wb_dat_o <= 32'h0000_0000;
            endcase
        end
    end

    property p_ack_rise;
        @(posedge clock_i) disable iff (rst_i)
        (ce_i && bus_req && !wb_ack_o) |=> wb_ack_o;
    endproperty
    a_ack_rise: assert property (p_ack_rise) else $error("ack late");

    property p_ack_drop;
        @(posedge clock_i) disable iff (rst_i)
        (ce_i && wb_ack_o) |=> !wb_ack_o;
    endproperty
    a_ack_drop: assert property (p_ack_drop) else $error("ack held");

    property p_a_attach;
        @(posedge clock_i) disable iff (rst_i)
        ce_i |=> (chan_a_attach_o == ($past(chan_a_outmode) != 2'h0));
    endproperty
    a_a_attach: assert property (p_a_attach) else $error("A attach");

    property p_a_comp;
        @(posedge clock_i) disable iff (rst_i)
        (ce_i && !six_out && (!chan_a_pwm_enable ||
         chan_a_outmode != `CMC_OM_TOGGLE)) |=> !chan_a_n_attach_o;
    endproperty
    a_a_comp: assert property (p_a_comp) else $error("A comp attach");

    property p_b_comp;
        @(posedge clock_i) disable iff (rst_i)
        (ce_i && !six_out && chan_b_pwm_enable &&
         chan_b_outmode == `CMC_OM_TOGGLE) |=> chan_b_n_attach_o;
    endproperty
    a_b_comp: assert property (p_b_comp) else $error("B comp attach");

    property p_b_attach;
        @(posedge clock_i) disable iff (rst_i)
        (ce_i && !six_out) |=>
            (chan_b_attach_o == ($past(chan_b_outmode) != 2'h0));
    endproperty
    a_b_attach: assert property (p_b_attach) else $error("B attach");

    property p_six_pins;
        @(posedge clock_i) disable iff (rst_i)
        (ce_i && six_out && att_a) |=>
            (chan_b_compare_pin_o == $past(wave_a)) &&
            (chan_b_compare_pin_n_o == !$past(wave_a));
    endproperty
    a_six_pins: assert property (p_six_pins) else $error("six-out pins");

    property p_b_mode;
        @(posedge clock_i) disable iff (rst_i)
        chan_b_pwm_enable |-> (mode_b == (waveform_gen_sel_bit0 ?
                                          CMC_M_PFC : CMC_M_FAST));
    endproperty
    a_b_mode: assert property (p_b_mode) else $error("B uses bit1");

    property p_match;
        @(posedge clock_i) disable iff (rst_i)
        ce_i |=> (match_a_seen == ($past(fast_timer_count_i) ==
                                   $past(chan_a_compare_value)));
    endproperty
    a_match: assert property (p_match) else $error("A match");

endmodule : cmc_top

//--- cmc_wave_unit.sv
// Waveform register of one compare channel.
// Assumes match, bottom and direction arrive on the same clock.
`timescale 1ns/100ps
`include "cmc_cfg.svh"

module cmc_wave_unit
    import cmc_pkg::*;
(
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic ce_i,
    cmc_chan_if.unit ch
);

    logic wave;
    assign ch.waveform = wave;

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            wave <= 1'b0;
        end else if (ce_i) begin
            case (ch.mode)
                CMC_M_NORMAL: begin
                    if (ch.match) begin
                        case (ch.outmode)
                            `CMC_OM_TOGGLE: wave <= ~wave;
                            `CMC_OM_CLEAR: wave <= 1'b0;
                            `CMC_OM_SET: wave <= 1'b1;
                            default: wave <= wave;
                        endcase
                    end
                end
                // Match beats bottom when the compare value is zero
                CMC_M_FAST, CMC_M_SS6: begin
                    if (ch.outmode != `CMC_OM_OFF) begin
                        if (ch.match) begin
                            wave <= (ch.outmode == `CMC_OM_SET);
                        end else if (ch.bottom) begin
                            wave <= (ch.outmode != `CMC_OM_SET);
                        end
                    end
                end
                CMC_M_PFC, CMC_M_DS6: begin
                    if ((ch.outmode != `CMC_OM_OFF) && ch.match) begin
                        // Up-count clears for 01/10, down-count reverses
                        wave <= (ch.outmode == `CMC_OM_SET) ^ ch.down;
                    end
                end
                default: wave <= wave;
            endcase
        end
    end

    property p_toggle;
        @(posedge clock_i) disable iff (rst_i)
        (ce_i && ch.mode == CMC_M_NORMAL && ch.match &&
         ch.outmode == `CMC_OM_TOGGLE) |=> (wave != $past(wave));
    endproperty
    a_toggle: assert property (p_toggle) else $error("toggle missed");

    property p_fast_bottom;
        @(posedge clock_i) disable iff (rst_i)
        (ce_i && (ch.mode == CMC_M_FAST || ch.mode == CMC_M_SS6) &&
         ch.bottom && !ch.match && ch.outmode != `CMC_OM_OFF)
        |=> (wave == ($past(ch.outmode) != `CMC_OM_SET));
    endproperty
    a_fast_bottom: assert property (p_fast_bottom)
        else $error("bottom level wrong");

    property p_fast_match;
        @(posedge clock_i) disable iff (rst_i)
        (ce_i && ch.mode == CMC_M_FAST && ch.match &&
         ch.outmode == `CMC_OM_CLEAR) |=> !wave;
    endproperty
    a_fast_match: assert property (p_fast_match)
        else $error("fast match not cleared");

    property p_dual;
        @(posedge clock_i) disable iff (rst_i)
        (ce_i && (ch.mode == CMC_M_PFC || ch.mode == CMC_M_DS6) &&
         ch.match && ch.outmode != `CMC_OM_OFF)
        |=> (wave == (($past(ch.outmode) == `CMC_OM_SET) ^ $past(ch.down)));
    endproperty
    a_dual: assert property (p_dual) else $error("dual slope level");

    property p_hold;
        @(posedge clock_i) disable iff (rst_i)
        !ce_i |=> $stable(wave);
    endproperty
    a_hold: assert property (p_hold) else $error("moved while frozen");

endmodule : cmc_wave_unit

//--- tb_top.sv
// Self-checking bench of the compare output mode controller.
// Assumes cmc_cfg.svh and cmc_top; the bench drives every port itself.
`timescale 1ns/100ps
`include "cmc_cfg.svh"

module tb_top;
    logic clock_i = 1'b0;
    logic rst_i = 1'b1;
    logic ce_i = 1'b1;
    logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [3:0] adr = 4'h0, sel = 4'h0;
    logic [31:0] dat = 32'h0, dat_o;
    logic ack, oa, oan, ob, obn, aa, aan, ab, abn, wfa, wfb;
    logic [9:0] cnt = 10'h3FF;
    logic dn = 1'b0, pa = 1'b0, pan = 1'b0, pb = 1'b0, pbn = 1'b0;
    logic [9:0] ctrl = 10'h000, cmpa = 10'h000, cmpb = 10'h000;
    logic chk = 1'b0, wa_m, wa_d, wb_m, wb_d;
    int err_count = 0;
    int checks_done = 0;

    cmc_top cmc_top_i (.clock_i(clock_i), .rst_i(rst_i), .ce_i(ce_i),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack),
        .fast_timer_count_i(cnt), .count_down_i(dn), .port_a_i(pa),
        .port_a_n_i(pan), .port_b_i(pb), .port_b_n_i(pbn),
        .chan_a_compare_pin_o(oa), .chan_a_compare_pin_n_o(oan),
        .chan_b_compare_pin_o(ob), .chan_b_compare_pin_n_o(obn),
        .chan_a_attach_o(aa), .chan_a_n_attach_o(aan),
        .chan_b_attach_o(ab), .chan_b_n_attach_o(abn),
        .chan_a_waveform_o(wfa), .chan_b_waveform_o(wfb));

    wire [1:0] aom = ctrl[`CMC_CTRL_AOM +: 2];
    wire [1:0] bom = ctrl[`CMC_CTRL_BOM +: 2];
    wire [1:0] wgm = ctrl[`CMC_CTRL_WGM +: 2];
    wire pwa = ctrl[`CMC_CTRL_PWMA];
    wire pwb = ctrl[`CMC_CTRL_PWMB];
    // Six-output: the B pair follows the A pair, attach and waveform
    wire six = pwa & wgm[1];
    wire ov = six & (aom != 2'h0);
    wire [1:0] ka = !pwa ? 2'h0 : (wgm[0] ? 2'h2 : 2'h1);
    wire [1:0] kb = !pwb ? 2'h0 : (wgm[0] ? 2'h2 : 2'h1);
    wire xa = aom != 2'h0;
    wire xan = (pwa & aom == 2'h1) | ov;
    wire xb = six ? xa : (bom != 2'h0);
    wire xbn = six ? xan : (pwb & bom == 2'h1);
    wire ws = six ? wa_d : wb_d;

    initial begin
        forever #4 clock_i = ~clock_i;
    end

    // Kind 0 non-PWM, 1 single slope, 2 dual slope; match beats bottom
    function automatic logic nextw(input logic [1:0] k, input logic [1:0] om,
        input logic m, input logic bot, input logic d, input logic w);
        if (om == `CMC_OM_OFF) return w;
        if (k == 2'h0) return !m ? w : (om == `CMC_OM_TOGGLE ? !w :
                                        om == `CMC_OM_SET);
        if (k == 2'h1) return m ? om == `CMC_OM_SET :
                                  (bot ? om != `CMC_OM_SET : w);
        return m ? (om == `CMC_OM_SET) ^ d : w;
    endfunction : nextw

    function automatic logic [9:0] mg(input logic [9:0] o,
        input logic [31:0] d, input logic [3:0] s);
        return {s[1] ? d[9:8] : o[9:8], s[0] ? d[7:0] : o[7:0]};
    endfunction : mg

    always @(posedge clock_i) begin
        if (rst_i) begin
            {wa_m, wa_d, wb_m, wb_d} <= 4'h0;
        end else if (ce_i) begin
            wa_d <= wa_m;
            wb_d <= wb_m;
            wa_m <= nextw(ka, aom, cnt == cmpa, cnt == `CMC_BOTTOM, dn, wa_m);
            wb_m <= nextw(kb, bom, cnt == cmpb, cnt == `CMC_BOTTOM, dn, wb_m);
        end
    end

    task automatic check(input string n, input logic [31:0] seen,
                         input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", n, exp, seen);
        end
    endtask : check

    task automatic end_of_test();
        if (err_count == 0 && checks_done > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : end_of_test

    task automatic bus(input logic w, input logic [3:0] a,
        input logic [3:0] s, input logic [31:0] d, output logic [31:0] r);
        int n;
        @(posedge clock_i);
        {cyc, stb, we, adr, sel, dat} <= {2'b11, w, a, s, d};
        for (n = 0; n < 20; n++) begin
            @(posedge clock_i);
            if (ack === 1'b1) break;
        end
        r = dat_o;
        {cyc, stb, we} <= 3'b000;
        if (n == 20) begin
            err_count++;
            end_of_test();
        end
    endtask : bus

    task automatic wr(input logic [3:0] a, input logic [31:0] d,
                      input logic [3:0] s);
        logic [31:0] r;
        bus(1'b1, a, s, d, r);
        case (a)
            `CMC_ADR_CTRL: ctrl = mg(ctrl, d, s) & 10'h3F3;
            `CMC_ADR_CMPA: cmpa = mg(cmpa, d, s);
            `CMC_ADR_CMPB: cmpb = mg(cmpb, d, s);
            default: ;
        endcase
    endtask : wr

    always @(negedge clock_i) begin
        if (chk) begin
            check("wave_a", wfa, wa_d);
            check("wave_b", wfb, wb_d);
            check("att_a", aa, xa);
            check("att_a_n", aan, xan);
            check("att_b", ab, xb);
            check("att_b_n", abn, xbn);
            check("pin_a", oa, xa ? wa_d : pa);
            check("pin_a_n", oan, xan ? !wa_d : pan);
            check("pin_b", ob, xb ? ws : pb);
            check("pin_b_n", obn, xbn ? !ws : pbn);
        end
    end

    initial begin
        logic [31:0] rd;
        logic [3:0] al [5];
        int unsigned s;
        al = '{`CMC_ADR_CTRL, `CMC_ADR_CMPA, `CMC_ADR_CMPB, `CMC_ADR_STAT,
               4'h2};
        s = $urandom(32'hF6F5);
        repeat (8) @(posedge clock_i);
        rst_i <= 1'b0;
        for (int k = 0; k < 5; k++) begin
            bus(1'b0, al[k], 4'hF, 32'h0, rd);
            check("reset_reg", rd, 32'h0);
        end
        for (int i = 0; i < 64; i++) begin
            cnt <= 10'h3FF;
            if (i % 8 == 0) begin
                wr(`CMC_ADR_CMPA, $urandom_range(1000), 4'h3);
                wr(`CMC_ADR_CMPB, $urandom_range(1000), 4'h3);
                wr(`CMC_ADR_STAT, 32'hFF, 4'hF);
                wr(4'h2, 32'h3FF, 4'hF);
            end
            wr(`CMC_ADR_CTRL, {i[3:2], i[1:0], 2'($urandom), 2'h0, i[4], i[5]},
               4'h3);
            bus(1'b0, `CMC_ADR_CTRL, 4'hF, 32'h0, rd);
            check("ctrl", rd, {22'h0, ctrl});
            {pa, pan, pb, pbn} <= 4'($urandom);
            repeat (3) @(posedge clock_i);
            chk <= 1'b1; // Config settles before pins are judged
            repeat (40) begin
                @(posedge clock_i);
                s = $urandom_range(3);
                cnt <= s == 0 ? `CMC_BOTTOM : s == 1 ? cmpa :
                       s == 2 ? cmpb : 10'($urandom);
                dn <= 1'($urandom);
                ce_i <= $urandom_range(7) != 0;
            end
            @(posedge clock_i);
            {chk, ce_i} <= 2'b01;
            cnt <= 10'h3FF;
            repeat (2) @(posedge clock_i);
            bus(1'b0, `CMC_ADR_STAT, 4'hF, 32'h0, rd);
            check("stat", rd, {26'h0, xbn, xb, xan, xa, wb_m, wa_m});
        end
        // Modes off so waves hold while the counter rests on compare A
        wr(`CMC_ADR_CTRL, 32'h3FF, 4'h1);
        bus(1'b0, `CMC_ADR_CTRL, 4'hF, 32'h0, rd);
        check("ctrl_lane", rd, {22'h0, ctrl});
        wr(`CMC_ADR_CTRL, 32'h0, 4'h3);
        cnt <= cmpa;
        repeat (2) @(posedge clock_i);
        bus(1'b0, `CMC_ADR_STAT, 4'hF, 32'h0, rd);
        check("match_a", rd[`CMC_STAT_MATCH_A], 1'b1);
        check("match_b", rd[`CMC_STAT_MATCH_B], cmpa == cmpb);
        end_of_test();
    end
endmodule : tb_top
